// ===== src/tpw_top.sv
`timescale 1ns/1ns
// Operation
// - Tone pin toggles on each overflow: tone is half the overflow rate.
// - Tone enabled takes the shared pin from GPIO and drives the tone unless PWM output is also enabled.
// - Clearing timer enable halts counting and stops tone and PWM.
// - Prescale select is mode bits 4..6, ignored for external events.
// - In PWM, reload and tone bits pick modulus 256, 64, 32 or 16.
// - PWM high while count below reference, low once equal or above.
// - Count wrap to zero is overflow and sets PWM high again for a nonzero reference.
// - Reference zero keeps PWM low for the whole period.
// - Reference writes are buffered and go active at next overflow.
// - Reference is write-only; software writes plain computed values.
// - PWM output enable routes PWM to shared pin, GPIO off.
// - Interrupt flag still rises on each overflow in PWM mode.
// - Clock source bit: 0 internal prescaled, 1 external event pin.
// - In PWM mode reload is automatic; reload and tone bits pick the boundary.
module tpw_top #(
	parameter int unsigned EXT_SYNC_STAGES = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire tpw_pkg::tpw_apb_req_t apb_req,
	output tpw_pkg::tpw_apb_rsp_t apb_rsp,
	// External event pin, asynchronous
	input wire logic ext_event_pin,
	// General-purpose port driver of the shared pin
	input wire logic gpio_o,
	input wire logic gpio_oe,
	// Shared output pin
	output tpw_pkg::tpw_pin_t shared_output_pin,
	// Timer interrupt request, flag gated by enable
	output logic timer_irq_req
);

	initial begin
		if (EXT_SYNC_STAGES < 2) begin
			$error("tpw_top needs at least two sync stages");
		end
	end

	tpw_pkg::tpw_state_t s_q;
	tpw_pkg::tpw_state_t s_d;
	logic ext_s;

	// External event pin crosses into pclk before anything reads it
	tpw_sync #(
		.STAGES(EXT_SYNC_STAGES)
	) u_ext_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(ext_event_pin),
		.q(ext_s)
	);

	// Decoded mode fields
	logic timer_enable_bit;
	logic pwm_output_enable;
	logic tone_output_enable;
	logic reload_select;
	logic clock_source_select;
	logic [2:0] prescale_select;

	assign timer_enable_bit = s_q.mode[tpw_pkg::MODE_ENABLE];
	assign pwm_output_enable = s_q.mode[tpw_pkg::MODE_PWM_OUT];
	assign tone_output_enable = s_q.mode[tpw_pkg::MODE_TONE_OUT];
	assign reload_select = s_q.mode[tpw_pkg::MODE_RELOAD];
	assign clock_source_select = s_q.mode[tpw_pkg::MODE_CLK_SRC];
	assign prescale_select =
		s_q.mode[tpw_pkg::MODE_RATE_MSB:tpw_pkg::MODE_RATE_LSB];

	// APB phase decode; one wait state so read data comes from a flop
	logic acc;
	logic acc_done;
	logic wr;
	logic hit_mode;
	logic hit_count;
	logic hit_ref;
	logic hit_irq;
	logic hit_any;

	assign acc = apb_req.psel & apb_req.penable;
	assign acc_done = acc & s_q.rsp.pready;
	assign wr = acc_done & apb_req.pwrite;
	assign hit_mode = apb_req.paddr == tpw_pkg::ADDR_MODE;
	assign hit_count = apb_req.paddr == tpw_pkg::ADDR_COUNT;
	assign hit_ref = apb_req.paddr == tpw_pkg::ADDR_REF;
	assign hit_irq = apb_req.paddr == tpw_pkg::ADDR_IRQ;
	assign hit_any = hit_mode | hit_count | hit_ref | hit_irq;

	// Prescaler tick: all ones in the low (8 - rate) bits of the divider
	logic [7:0] pre_mask;
	logic pre_tick;
	logic ext_tick;
	logic step;

	assign pre_mask = tpw_pkg::PRE_FULL >> prescale_select;
	assign pre_tick = &(s_q.div | ~pre_mask);
	assign ext_tick = ext_s & ~s_q.ext_prev;

	// Source choice; the rate field plays no part for events
	assign step = timer_enable_bit &
		(clock_source_select ? ext_tick : pre_tick);

	// Modulus mask: 256 unless PWM picks a shorter period
	logic [7:0] mod_mask;

	always_comb begin
		mod_mask = tpw_pkg::MOD_256;
		if (pwm_output_enable) begin
			case ({reload_select, tone_output_enable})
				2'b00: mod_mask = tpw_pkg::MOD_256;
				2'b01: mod_mask = tpw_pkg::MOD_64;
				2'b10: mod_mask = tpw_pkg::MOD_32;
				2'b11: mod_mask = tpw_pkg::MOD_16;
				default: mod_mask = tpw_pkg::MOD_256;
			endcase
		end
	end

	// Overflow: the masked count sits at the top of the modulus
	logic [7:0] cnt_m;
	logic ovf;

	assign cnt_m = s_q.cnt & mod_mask;
	assign ovf = step & (cnt_m == mod_mask);

	// Next state of the whole block
	always_comb begin
		s_d = s_q;

		// Divider runs freely so the rate can change without a restart
		s_d.div = s_q.div + 8'h01;
		s_d.ext_prev = ext_s;

		// Counting; reload of the reference only outside PWM
		if (ovf) begin
			s_d.ref_act = s_q.ref_buf;
			if (!pwm_output_enable && reload_select) begin
				s_d.cnt = s_q.ref_buf;
			end else begin
				s_d.cnt = tpw_pkg::COUNT_RST;
			end
		end else if (step) begin
			s_d.cnt = cnt_m + 8'h01;
		end

		// Overflow raises the flag in every mode, PWM included
		if (ovf) begin
			s_d.irq_flag = 1'b1;
		end

		// Tone toggles once per overflow, half the overflow rate
		if (ovf && tone_output_enable && !pwm_output_enable) begin
			s_d.tone = ~s_q.tone;
		end

		// Register writes take effect at the completing edge only
		if (wr && hit_mode) begin
			s_d.mode = apb_req.pwdata[7:0];
		end
		if (wr && hit_count) begin
			s_d.cnt = apb_req.pwdata[7:0];
		end
		if (wr && hit_ref) begin
			s_d.ref_buf = apb_req.pwdata[7:0];
		end
		if (wr && hit_irq) begin
			s_d.irq_en = apb_req.pwdata[tpw_pkg::IRQ_EN];
			// Writing zero clears; an overflow in the same cycle wins
			if (!apb_req.pwdata[tpw_pkg::IRQ_FLAG] && !ovf) begin
				s_d.irq_flag = 1'b0;
			end
		end
		s_d.irq_req = s_d.irq_flag & s_d.irq_en;

		// PWM level follows the compare, so a zero reference stays low
		s_d.pwm = timer_enable_bit & pwm_output_enable &
			((s_d.cnt & mod_mask) < (s_d.ref_act & mod_mask));
		if (!timer_enable_bit) begin
			s_d.pwm = 1'b0;
		end

		// Pin ownership: either output takes the pin away from GPIO
		s_d.pin.func = pwm_output_enable | tone_output_enable;
		if (pwm_output_enable) begin
			s_d.pin.o = s_d.pwm;
			s_d.pin.oe = 1'b1;
		end else if (tone_output_enable) begin
			// A stopped timer freezes the tone level rather than forcing it
			s_d.pin.o = s_q.tone;
			s_d.pin.oe = 1'b1;
		end else begin
			s_d.pin.o = gpio_o;
			s_d.pin.oe = gpio_oe;
		end

		// APB answer: ready one cycle into the access phase
		s_d.rsp.pready = acc & ~s_q.rsp.pready;
		s_d.rsp.pslverr = acc & ~s_q.rsp.pready & ~hit_any;
		s_d.rsp.prdata = 32'h0000_0000;
		if (acc && !s_q.rsp.pready && !apb_req.pwrite) begin
			if (hit_mode) begin
				s_d.rsp.prdata = {24'h00_0000, s_q.mode};
			end else if (hit_count) begin
				s_d.rsp.prdata = {24'h00_0000, s_q.cnt};
			end else if (hit_irq) begin
				s_d.rsp.prdata = {30'h0000_0000, s_q.irq_en,
					s_q.irq_flag};
			end
			// Reference reads as zero: the buffer is not readable
		end
	end

	// Single state register; reset leaves the pin to GPIO, tone low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.mode <= tpw_pkg::MODE_RST;
			s_q.cnt <= tpw_pkg::COUNT_RST;
			s_q.ref_buf <= tpw_pkg::REF_RST;
			s_q.ref_act <= tpw_pkg::REF_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops
	assign apb_rsp = s_q.rsp;
	assign shared_output_pin = s_q.pin;
	assign timer_irq_req = s_q.irq_req;

endmodule

// ===== inc/tpw_pkg.sv
package tpw_pkg;

	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_MODE = 8'hda;
	localparam logic [7:0] IDX_COUNT = 8'hdb;
	localparam logic [7:0] IDX_REF = 8'hcd;
	localparam logic [7:0] IDX_IRQ = 8'hc8;
	localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
	localparam logic [11:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
	localparam logic [11:0] ADDR_REF = {2'h0, IDX_REF, 2'h0};
	localparam logic [11:0] ADDR_IRQ = {2'h0, IDX_IRQ, 2'h0};

	// Mode register fields
	localparam int unsigned MODE_PWM_OUT = 0;
	localparam int unsigned MODE_TONE_OUT = 1;
	localparam int unsigned MODE_RELOAD = 2;
	localparam int unsigned MODE_CLK_SRC = 3;
	localparam int unsigned MODE_RATE_LSB = 4;
	localparam int unsigned MODE_RATE_MSB = 6;
	localparam int unsigned MODE_ENABLE = 7;

	// Interrupt register fields
	localparam int unsigned IRQ_FLAG = 0;
	localparam int unsigned IRQ_EN = 1;

	// Values after reset
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] REF_RST = 8'h00;

	// Count moduli as masks: 256, 64, 32, 16
	localparam logic [7:0] MOD_256 = 8'hff;
	localparam logic [7:0] MOD_64 = 8'h3f;
	localparam logic [7:0] MOD_32 = 8'h1f;
	localparam logic [7:0] MOD_16 = 8'h0f;

	// Prescaler: rate 0 divides by 256, rate 7 by 2
	localparam int unsigned PRE_W = 8;
	localparam logic [7:0] PRE_FULL = 8'hff;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} tpw_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tpw_apb_rsp_t;

	// Shared pin: level, enable, and whether the timer owns it
	typedef struct packed {
		logic o;
		logic oe;
		logic func;
	} tpw_pin_t;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] cnt;
		logic [7:0] ref_buf;
		logic [7:0] ref_act;
		logic irq_flag;
		logic irq_en;
		logic irq_req;
		logic [7:0] div;
		logic ext_prev;
		logic tone;
		logic pwm;
		tpw_pin_t pin;
		tpw_apb_rsp_t rsp;
	} tpw_state_t;

endpackage

// ===== src/tpw_sync.sv
`timescale 1ns/1ns
module tpw_sync #(
	parameter int unsigned STAGES = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous level in, synchronised level out
	input wire logic d,
	output logic q
);

	logic [STAGES-1:0] chain_q;

	// Fewer than two stages gives no protection against metastability
	initial begin
		if (STAGES < 2) begin
			$error("tpw_sync needs at least two stages");
		end
	end

	// Only the last stage is visible to the rest of the logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_q <= '0;
		end else begin
			chain_q <= {chain_q[STAGES-2:0], d};
		end
	end

	assign q = chain_q[STAGES-1];

endmodule

// ===== tb/tpw_properties.sv
`timescale 1ns/1ns
module tpw_properties (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire tpw_pkg::tpw_apb_req_t apb_req,
	input wire tpw_pkg::tpw_apb_rsp_t apb_rsp,
	// Pins
	input wire logic ext_event_pin,
	input wire logic gpio_o,
	input wire logic gpio_oe,
	input wire tpw_pkg::tpw_pin_t shared_output_pin,
	input wire logic timer_irq_req
);
	logic [7:0] mode_q;
	logic ien_q;
	logic own;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	assign own = |mode_q[1:0];
	// Shadow of mode and irq enable, taken as a write completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 8'h00;
			ien_q <= 1'b0;
		end else if (apb_req.psel && apb_req.pwrite && apb_rsp.pready) begin
			if (apb_req.paddr == tpw_pkg::ADDR_MODE)
				mode_q <= apb_req.pwdata[7:0];
			if (apb_req.paddr == tpw_pkg::ADDR_IRQ)
				ien_q <= apb_req.pwdata[1];
		end
	end
	AST_ONE_WAIT: assert property ($rose(apb_req.penable) && apb_req.psel
		|-> !apb_rsp.pready ##1 apb_rsp.pready) else $error("bad wait");
	AST_GPIO_PASS: assert property (
		$past(presetn) && !shared_output_pin.func |->
		{shared_output_pin.o, shared_output_pin.oe} ==
		{$past(gpio_o), $past(gpio_oe)}) else $error("pin not gpio");
	AST_OWNED: assert property (
		shared_output_pin.func == $past(own) &&
		(!shared_output_pin.func || shared_output_pin.oe))
		else $error("pin owner wrong");
	AST_PWM_OFF: assert property (
		(mode_q[0] && !mode_q[7]) [*2] |-> !shared_output_pin.o)
		else $error("pwm not stopped");
	AST_TONE_HOLD: assert property (
		(mode_q[1] && !mode_q[0] && !mode_q[7]) [*3]
		|-> $stable(shared_output_pin.o)) else $error("tone not frozen");
	// Rate bits set too, so a prescaler leak would move the pin
	AST_EXT_IDLE: assert property (
		(mode_q[3] && mode_q[1] && !mode_q[0] && !ext_event_pin) [*8]
		|-> $stable(shared_output_pin.o)) else $error("step without event");
	AST_IRQ_GATE: assert property (
		timer_irq_req |-> ien_q || $past(ien_q))
		else $error("irq while masked");
	AST_IRQ_RATE: assert property (
		$rose(ien_q && mode_q == 8'hf7) |-> ##[1:80] timer_irq_req)
		else $error("no overflow");
	C_PWM_HI: cover property (mode_q[0] && shared_output_pin.o);
	C_TONE: cover property (own && $changed(shared_output_pin.o));
	C_ERR: cover property (apb_rsp.pslverr);
endmodule
bind tpw_top tpw_properties tpw_properties_i (.pclk, .presetn, .apb_req,
	.apb_rsp, .ext_event_pin, .gpio_o, .gpio_oe, .shared_output_pin,
	.timer_irq_req);

// ===== tb/tpw_load.sv
`timescale 1ns/1ns
module tpw_load (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pin and edges heard
	input wire tpw_pkg::tpw_pin_t pin,
	output int edges
);
	logic last_q;
	// A buzzer hears level changes only while the timer drives the pin
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edges <= 0;
			last_q <= 1'b0;
		end else begin
			last_q <= pin.o;
			if (pin.oe && pin.func && pin.o !== last_q)
				edges <= edges + 1;
		end
	end
endmodule

// ===== tb/tpw_top_tb_top.sv
`timescale 1ns/1ns
module tpw_top_tb_top;
	tpw_pkg::tpw_apb_req_t req;
	tpw_pkg::tpw_apb_rsp_t rsp;
	tpw_pkg::tpw_pin_t pin;
	logic pclk, presetn, ext, gpio_o, gpio_oe, irq, err;
	logic [31:0] rd;
	logic [7:0] lf;
	logic [11:0] ad [4];
	int fail_count, comparisons, cyc, edges, m, r, e, k, b;
	tpw_top tpw_top_i (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp),
		.ext_event_pin(ext), .gpio_o, .gpio_oe, .shared_output_pin(pin),
		.timer_irq_req(irq));
	tpw_load tpw_load_i (.pclk, .presetn, .pin, .edges);
	// Clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Hang guard, some seven times the length of the whole run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One idle cycle after each transfer keeps drivers single per step
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		// Ready is taken at the rising edge, while the request still stands
		@(posedge pclk);
		while (rsp.pready !== 1'b1)
			@(posedge pclk);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge pclk);
	endtask
	// Stop, load count and reference, restart
	task automatic setup(input logic [31:0] cv, input logic [31:0] rv,
		input logic [31:0] md);
		bus(1'b1, tpw_pkg::ADDR_MODE, md & 32'h7e);
		bus(1'b1, tpw_pkg::ADDR_COUNT, cv);
		bus(1'b1, tpw_pkg::ADDR_REF, rv);
		bus(1'b1, tpw_pkg::ADDR_MODE, md);
	endtask
	task automatic wt(output int t);
		int s;
		s = edges;
		t = 0;
		while (edges == s) begin
			@(posedge pclk);
			t++;
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		req = '0;
		ext = 1'b0;
		gpio_o = 1'b1;
		gpio_oe = 1'b1;
		presetn = 1'b0;
		lf = 8'h08;
		ad = '{tpw_pkg::ADDR_MODE, tpw_pkg::ADDR_COUNT, tpw_pkg::ADDR_REF,
			12'h004};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		gpio_o <= lf[3];
		gpio_oe <= lf[2];
		repeat (3) @(posedge pclk);
		chk(pin, {lf[3], lf[2], 1'b0});
		bus(1'b1, tpw_pkg::ADDR_REF, 32'h55);
		foreach (ad[i]) begin
			bus(1'b0, ad[i], 32'h0);
			chk({err, rd}, {i == 3, 32'h0});
		end
		// Tone owns the pin at once, still low while the timer stands
		bus(1'b1, tpw_pkg::ADDR_MODE, 32'h02);
		repeat (2) @(posedge pclk);
		chk(pin, 3'b011);
		$display("reset test done");
		// Each modulus, measured over one whole period
		for (int c = 0; c < 4; c++) begin
			m = 256 >> (c == 0 ? 0 : c + 1);
			lf = nx(lf);
			r = c == 2 ? 0 : lf % m;
			setup(0, r, 32'hf1 | c << 1);
			e = 0;
			for (int j = 0; j < m; j++)
				e += j < r ? 2 : 0;
			repeat (4 * m + 4) @(posedge pclk);
			b = 0;
			repeat (2 * m) begin
				@(posedge pclk);
				b += pin.o;
			end
			chk(b, e);
		end
		bus(1'b1, tpw_pkg::ADDR_MODE, 32'h77);
		repeat (3) @(posedge pclk);
		chk(pin, 3'b011);
		$display("pwm test done");
		bus(1'b1, tpw_pkg::ADDR_IRQ, 32'h2);
		bus(1'b1, tpw_pkg::ADDR_MODE, 32'hf7);
		repeat (60) @(posedge pclk);
		bus(1'b0, tpw_pkg::ADDR_IRQ, 32'h0);
		chk({irq, rd}, {1'b1, 32'h3});
		bus(1'b1, tpw_pkg::ADDR_IRQ, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		$display("irq test done");
		// First edge may be partial, the last is a full interval
		lf = nx(lf);
		k = lf | 8'hc0;
		// Rate 6 steps every fourth clock; PWM bit stays clear for the tone
		setup(k, k, 32'he6);
		repeat (3) wt(b);
		chk({pin.func, b}, {1'b1, 4 * (256 - k)});
		$display("tone test done");
		setup(32'hfd, 32'hfd, 32'hfe);
		b = edges;
		for (int i = 1; i < 4; i++) begin
			ext <= 1'b1;
			repeat (3) @(posedge pclk);
			ext <= 1'b0;
			repeat (10) @(posedge pclk);
			chk(edges - b, i / 3);
		end
		$display("event test done");
		print_verdict();
	end
endmodule
